// ---- sdt_pkg.sv ----
package sdt_pkg;

    // ==========================================================
    // register map (byte addresses on the apb bus)
    localparam logic [7:0] SDT_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SDT_ADDR_COUNT = 8'h04;
    localparam logic [7:0] SDT_ADDR_RELOAD = 8'h08;
    localparam logic [7:0] SDT_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] SDT_ADDR_MASK = 8'h10;

    // ==========================================================
    // field positions and reset values
    localparam int SDT_FLAG_LOW = 0;
    localparam int SDT_FLAG_HIGH = 1;
    localparam logic [7:0] SDT_CTRL_RESET = 8'h00;
    localparam logic [15:0] SDT_PAIR_RESET = 16'h0000;
    localparam logic [1:0] SDT_FLAGS_RESET = 2'h0;
    localparam logic [1:0] SDT_MASK_RESET = 2'h3;
    localparam logic [7:0] SDT_ROLL_VALUE = 8'hff;

    // ==========================================================
    // external source codes
    localparam logic [1:0] SDT_XSEL_DIV12 = 2'h0;
    localparam logic [1:0] SDT_XSEL_RTC = 2'h1;
    localparam logic [1:0] SDT_XSEL_RSVD = 2'h2;
    localparam logic [1:0] SDT_XSEL_CMP0 = 2'h3;

    // ==========================================================
    // prescaler counts
    localparam logic [3:0] SDT_SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] SDT_RTC_DIV_LAST = 3'h7;

    // ==========================================================
    // types
    typedef struct packed {
        logic low_clock_select;
        logic high_clock_select;
        logic low_overflow_irq_enable;
        logic irq_enable;
        logic split_mode_select;
        logic run_control;
        logic [1:0] external_clock_select;
    } sdt_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } sdt_pair_t;

endpackage

// ---- sdt_split_timer.sv ----
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
// What this block does
// - With split mode selected the timer runs as two 8-bit auto-reload counters, high and low.
// - Each half reloads from its own reload register.
// - Run control gates only the high counter; the low counter is gated by split mode alone.
// - High clock select 1 counts system clocks, 0 uses the external select field.
// - External select 00 is system clock / 12, 01 rtc / 8, 11 comparator 0, 10 reserved.
// - The low clock select chooses its source the same way, sharing the high half's external select field.
// - A rollover from ff, which loads the reload value, sets that half's overflow flag.
// - With the timer interrupt enabled, every high overflow with its mask bit set requests an interrupt.
// - With low overflow interrupt enable also set, either half's unmasked overflow requests an interrupt.
// - Hardware never clears the overflow flags; only software does.
module sdt_split_timer
    import sdt_pkg::*;
(
    input wire logic core_clk_in, // 25 MHz system clock
    input wire logic sys_rst_in, // synchronous reset, high
    input wire logic rtc_clk_in, // real-time clock pin
    input wire logic cmp0_in, // comparator 0 output
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [7:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error, unmapped address
    output logic irq_out // timer interrupt level
);

    // ==========================================================
    // source selection
    function automatic logic src_tick(input logic sys_sel, input logic [1:0] xsel,
                                      input logic t12, input logic trtc, input logic tcmp);
        logic t;
        t = 1'b0;
        if (sys_sel)
            t = 1'b1;
        else if (xsel == SDT_XSEL_DIV12)
            t = t12;
        else if (xsel == SDT_XSEL_RTC)
            t = trtc;
        else if (xsel == SDT_XSEL_CMP0)
            t = tcmp;
        else
            t = 1'b0;
        return t;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == SDT_ADDR_CTRL) || (a == SDT_ADDR_COUNT) || (a == SDT_ADDR_RELOAD)
            || (a == SDT_ADDR_STATUS) || (a == SDT_ADDR_MASK);
    endfunction

    // ==========================================================
    // state
    sdt_ctrl_t ctrl, next_ctrl;
    sdt_pair_t count, next_count;
    sdt_pair_t reload, next_reload;
    logic [1:0] flags, next_flags;
    logic [1:0] mask, next_mask;
    logic [31:0] rdata, next_rdata;
    logic err, next_err;
    logic [3:0] sys_div, next_sys_div;
    logic [2:0] rtc_div, next_rtc_div;
    logic [2:0] rtc_sync, next_rtc_sync;
    logic [2:0] cmp_sync, next_cmp_sync;

    logic setup, access, wr_acc;
    logic wr_ctrl, wr_count, wr_reload, wr_status, wr_mask;
    logic tick12, tick_rtc, tick_cmp;
    logic low_tick, high_tick, low_ovf, high_ovf;

    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in;
    assign wr_acc = access && pwrite_in;
    assign wr_ctrl = wr_acc && (paddr_in == SDT_ADDR_CTRL);
    assign wr_count = wr_acc && (paddr_in == SDT_ADDR_COUNT);
    assign wr_reload = wr_acc && (paddr_in == SDT_ADDR_RELOAD);
    assign wr_status = wr_acc && (paddr_in == SDT_ADDR_STATUS);
    assign wr_mask = wr_acc && (paddr_in == SDT_ADDR_MASK);

    // ==========================================================
    // count sources
    // edges only after the second sync stage
    assign tick_rtc = rtc_sync[1] && !rtc_sync[2] && (rtc_div == SDT_RTC_DIV_LAST);
    assign tick_cmp = cmp_sync[1] && !cmp_sync[2];
    assign tick12 = (sys_div == SDT_SYS_DIV_LAST);

    // shared external mapping, code 10 never ticks
    // run control gates the high half only
    assign high_tick = ctrl.split_mode_select && ctrl.run_control
        && src_tick(ctrl.high_clock_select, ctrl.external_clock_select, tick12, tick_rtc, tick_cmp);
    // low half picks its own source
    assign low_tick = ctrl.split_mode_select
        && src_tick(ctrl.low_clock_select, ctrl.external_clock_select, tick12, tick_rtc, tick_cmp);
    assign high_ovf = high_tick && (count.high == SDT_ROLL_VALUE);
    assign low_ovf = low_tick && (count.low == SDT_ROLL_VALUE);

    always_comb
    begin
        next_rtc_sync = {rtc_sync[1:0], rtc_clk_in};
        next_cmp_sync = {cmp_sync[1:0], cmp0_in};
        next_sys_div = tick12 ? 4'h0 : sys_div + 4'h1;
        next_rtc_div = rtc_div;
        // rtc divided by 8: every eighth rising edge ticks
        if (rtc_sync[1] && !rtc_sync[2])
            next_rtc_div = rtc_div + 3'h1;
    end

    // ==========================================================
    // counters and flags
    always_comb
    begin
        next_count = count;
        if (low_ovf)
            next_count.low = reload.low;
        else if (low_tick)
            next_count.low = count.low + 8'h01;
        // high reload from its own register
        if (high_ovf)
            next_count.high = reload.high;
        else if (high_tick)
            next_count.high = count.high + 8'h01;
        // software write of the counters overrides a tick
        if (wr_count)
            next_count = pwdata_in[15:0];

        // only a software one-write clears, set wins
        next_flags = flags;
        if (wr_status)
            next_flags = flags & ~pwdata_in[1:0];
        if (low_ovf)
            next_flags[SDT_FLAG_LOW] = 1'b1;
        if (high_ovf)
            next_flags[SDT_FLAG_HIGH] = 1'b1;
    end

    // ==========================================================
    // register file
    always_comb
    begin
        next_ctrl = wr_ctrl ? sdt_ctrl_t'(pwdata_in[7:0]) : ctrl;
        next_reload = wr_reload ? pwdata_in[15:0] : reload;
        next_mask = wr_mask ? pwdata_in[1:0] : mask;
        next_rdata = rdata;
        next_err = err;
        // read data and error are latched in the setup cycle
        if (setup)
        begin
            next_err = !mapped(paddr_in);
            if (paddr_in == SDT_ADDR_CTRL)
                next_rdata = {24'h000000, ctrl};
            else if (paddr_in == SDT_ADDR_COUNT)
                next_rdata = {16'h0000, count};
            else if (paddr_in == SDT_ADDR_RELOAD)
                next_rdata = {16'h0000, reload};
            else if (paddr_in == SDT_ADDR_STATUS)
                next_rdata = {30'h0, flags};
            else if (paddr_in == SDT_ADDR_MASK)
                next_rdata = {30'h0, mask};
            else
                next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl <= sdt_ctrl_t'(SDT_CTRL_RESET);
            count <= SDT_PAIR_RESET;
            reload <= SDT_PAIR_RESET;
            flags <= SDT_FLAGS_RESET;
            mask <= SDT_MASK_RESET;
            rdata <= 32'h00000000;
            err <= 1'b0;
            sys_div <= 4'h0;
            rtc_div <= 3'h0;
            rtc_sync <= 3'h0;
            cmp_sync <= 3'h0;
        end
        else
        begin
            ctrl <= next_ctrl;
            count <= next_count;
            reload <= next_reload;
            flags <= next_flags;
            mask <= next_mask;
            rdata <= next_rdata;
            err <= next_err;
            sys_div <= next_sys_div;
            rtc_div <= next_rtc_div;
            rtc_sync <= next_rtc_sync;
            cmp_sync <= next_cmp_sync;
        end
    end

    // ==========================================================
    // outputs
    assign pready_out = access;
    assign prdata_out = rdata;
    assign pslverr_out = access && err;
    // low overflow only with its own enable
    assign irq_out = ctrl.irq_enable && ((flags[SDT_FLAG_HIGH] && mask[SDT_FLAG_HIGH])
        || (ctrl.low_overflow_irq_enable && flags[SDT_FLAG_LOW] && mask[SDT_FLAG_LOW]));

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence low_wraps_s;
        low_tick && count.low == SDT_ROLL_VALUE && !wr_count;
    endsequence

    sequence prescale_period_s;
        (!tick12) [*8] ##1 (!tick12) [*3] ##1 tick12;
    endsequence

    // a set flag with no status register write in this cycle
    sequence high_flag_held_s;
        flags[SDT_FLAG_HIGH] && !wr_status;
    endsequence

    sequence low_flag_held_s;
        flags[SDT_FLAG_LOW] && !wr_status;
    endsequence

    split_off_idle_a: assert property (
        !ctrl.split_mode_select && !wr_count |=> $stable(count))
        else $error("counters moved outside split mode");

    low_reload_a: assert property (
        low_wraps_s |=> count.low == $past(reload.low) && flags[SDT_FLAG_LOW])
        else $error("low half did not reload with its flag");

    high_reload_a: assert property (
        high_tick && count.high == SDT_ROLL_VALUE && !wr_count |=> count.high == $past(reload.high))
        else $error("high half did not load its reload value");

    high_run_gate_a: assert property (
        !ctrl.run_control && !wr_count |=> $stable(count.high))
        else $error("high half counted while stopped");

    low_free_run_a: assert property (
        ctrl.split_mode_select && ctrl.low_clock_select && count.low != SDT_ROLL_VALUE && !wr_count
        |=> count.low == $past(count.low) + 8'h01)
        else $error("low half missed a system clock count");

    high_system_clock_a: assert property (
        ctrl.split_mode_select && ctrl.run_control && ctrl.high_clock_select
        && count.high != SDT_ROLL_VALUE && !wr_count |=> count.high == $past(count.high) + 8'h01)
        else $error("high half missed a system clock count");

    prescale_rate_a: assert property (
        tick12 |=> prescale_period_s)
        else $error("divide by 12 prescaler off rate");

    reserved_code_a: assert property (
        ctrl.external_clock_select == SDT_XSEL_RSVD && !ctrl.low_clock_select
        && !wr_count |=> $stable(count.low))
        else $error("reserved source advanced the low half");

    high_xsel_gate_a: assert property (
        !ctrl.high_clock_select && ctrl.external_clock_select == SDT_XSEL_CMP0 && !tick_cmp
        && !wr_count |=> $stable(count.high))
        else $error("high half counted without a comparator edge");

    low_xsel_gate_a: assert property (
        !ctrl.low_clock_select && ctrl.external_clock_select == SDT_XSEL_CMP0 && !tick_cmp
        && !wr_count |=> $stable(count.low))
        else $error("low half counted without a comparator edge");

    high_flag_set_a: assert property (
        high_ovf |=> flags[SDT_FLAG_HIGH])
        else $error("high overflow flag not set");

    flag_sticky_a: assert property (
        high_flag_held_s |=> flags[SDT_FLAG_HIGH])
        else $error("high flag cleared by hardware");

    low_flag_sticky_a: assert property (
        low_flag_held_s |=> flags[SDT_FLAG_LOW])
        else $error("low flag cleared by hardware");

    low_flag_set_a: assert property (
        low_ovf |=> flags[SDT_FLAG_LOW])
        else $error("low overflow flag not set");

    irq_high_a: assert property (
        ctrl.irq_enable && mask[SDT_FLAG_HIGH] && high_ovf && !wr_ctrl && !wr_mask |=> irq_out)
        else $error("high overflow gave no interrupt");

    irq_low_a: assert property (
        flags == 2'h1 && !ctrl.low_overflow_irq_enable |-> !irq_out)
        else $error("low overflow interrupted without its enable");

    irq_low_on_a: assert property (
        ctrl.irq_enable && ctrl.low_overflow_irq_enable && mask[SDT_FLAG_LOW] && low_ovf
        && !wr_ctrl && !wr_mask |=> irq_out)
        else $error("low overflow gave no interrupt");

    cmp_single_a: assert property (
        tick_cmp |=> !tick_cmp)
        else $error("comparator edge counted twice");

endmodule // sdt_split_timer

// ---- sdt_split_timer_tb.sv ----
`timescale 1ns/1ns
module sdt_split_timer_tb;
    import sdt_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic err;
    } sdt_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rtc = 1'b0;
    logic cmp = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] r;
    logic e;
    int n_errors = 0;
    int checked = 0;
    // ==========================================================
    // ordinary register accesses; read rows carry expected data
    sdt_row_t rows [0:9] = '{
        '{1'b1, SDT_ADDR_RELOAD, 32'h1234, 1'b0}, '{1'b0, SDT_ADDR_RELOAD, 32'h1234, 1'b0},
        '{1'b1, SDT_ADDR_COUNT, 32'h5678, 1'b0}, '{1'b0, SDT_ADDR_COUNT, 32'h5678, 1'b0},
        '{1'b1, SDT_ADDR_MASK, 32'h1, 1'b0}, '{1'b0, SDT_ADDR_MASK, 32'h1, 1'b0},
        '{1'b1, SDT_ADDR_CTRL, 32'ha5, 1'b0}, '{1'b0, SDT_ADDR_CTRL, 32'ha5, 1'b0},
        '{1'b1, 8'h20, 32'hdead, 1'b1}, '{1'b0, 8'h20, 32'h0, 1'b1}};

    sdt_split_timer sdt_split_timer_inst (
        .core_clk_in(clk), .sys_rst_in(rst), .rtc_clk_in(rtc), .cmp0_in(cmp),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq)
    );

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic inrange(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi, input string m);
        checked++;
        if ($isunknown(v) || v < lo || v > hi)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h", $time, m, v);
        end
    endtask

    // ==========================================================
    // apb master: holds the request until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        xfer(1'b0, a, 32'h0);
        chk(r, exp, m);
        chk({31'h0, e}, 32'h0, m);
    endtask

    task automatic irqchk(input logic exp);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp}, "irq");
    endtask

    // slow pulses so every edge survives the two-flop synchroniser
    task automatic edges(input logic on_rtc, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (on_rtc)
                rtc <= 1'b1;
            else
                cmp <= 1'b1;
            repeat (3) @(posedge clk);
            rtc <= 1'b0;
            cmp <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        #(40 * 20000);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            xfer(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk(r, rows[i].d, "row data");
            chk({31'h0, e}, {31'h0, rows[i].err}, "row error");
        end
        // ======================================================
        // second reset with dirty state
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(SDT_ADDR_CTRL, 32'h0, "ctrl reset");
        rd(SDT_ADDR_COUNT, 32'h0, "count reset");
        rd(SDT_ADDR_RELOAD, 32'h0, "reload reset");
        rd(SDT_ADDR_STATUS, 32'h0, "status reset");
        rd(SDT_ADDR_MASK, 32'h3, "mask reset");
        irqchk(1'b0);
        // ======================================================
        // comparator source, exact reload and flags
        wr(SDT_ADDR_RELOAD, 32'h2240);
        wr(SDT_ADDR_COUNT, 32'hfffe);
        wr(SDT_ADDR_CTRL, 32'h1b);
        edges(1'b0, 2);
        rd(SDT_ADDR_COUNT, 32'hff40, "low reload, high stopped");
        rd(SDT_ADDR_STATUS, 32'h1, "low flag");
        irqchk(1'b0);
        edges(1'b0, 1);
        rd(SDT_ADDR_COUNT, 32'hff41, "one per edge");
        rd(SDT_ADDR_STATUS, 32'h1, "flag sticky");
        wr(SDT_ADDR_CTRL, 32'h3b);
        irqchk(1'b1);
        wr(SDT_ADDR_MASK, 32'h2);
        irqchk(1'b0);
        wr(SDT_ADDR_STATUS, 32'h1);
        rd(SDT_ADDR_STATUS, 32'h0, "flag cleared");
        wr(SDT_ADDR_MASK, 32'h3);
        wr(SDT_ADDR_CTRL, 32'h1f);
        edges(1'b0, 1);
        rd(SDT_ADDR_COUNT, 32'h2242, "high reload");
        rd(SDT_ADDR_STATUS, 32'h2, "high flag");
        irqchk(1'b1);
        wr(SDT_ADDR_STATUS, 32'h2);
        irqchk(1'b0);
        // ======================================================
        // rtc divided by eight, then the reserved code
        wr(SDT_ADDR_COUNT, 32'h0);
        wr(SDT_ADDR_CTRL, 32'h09);
        edges(1'b1, 7);
        rd(SDT_ADDR_COUNT, 32'h0, "rtc seven edges");
        edges(1'b1, 1);
        rd(SDT_ADDR_COUNT, 32'h1, "rtc eighth edge");
        wr(SDT_ADDR_CTRL, 32'h0a);
        edges(1'b1, 8);
        edges(1'b0, 2);
        rd(SDT_ADDR_COUNT, 32'h1, "reserved source");
        // ======================================================
        // system clock / 12, then system clock on each half alone
        wr(SDT_ADDR_CTRL, 32'h08);
        repeat (120) @(posedge clk);
        wr(SDT_ADDR_CTRL, 32'h0);
        // prescaler phase runs free: 123 counted edges give 10 or 11 ticks on top of 1
        xfer(1'b0, SDT_ADDR_COUNT, 32'h0);
        inrange(r[7:0], 8'h0b, 8'h0c, "low on system clock / 12");
        chk({24'h0, r[15:8]}, 32'h0, "high stopped");
        wr(SDT_ADDR_COUNT, 32'h0);
        wr(SDT_ADDR_CTRL, 32'h4f);
        repeat (50) @(posedge clk);
        wr(SDT_ADDR_CTRL, 32'h0);
        xfer(1'b0, SDT_ADDR_COUNT, 32'h0);
        // 50 idle edges plus the three of the stopping write
        inrange(r[15:8], 8'h35, 8'h35, "high on system clock");
        chk(r, 32'h00003500, "low idle");
        wr(SDT_ADDR_COUNT, 32'h0);
        wr(SDT_ADDR_CTRL, 32'h8b);
        repeat (50) @(posedge clk);
        wr(SDT_ADDR_CTRL, 32'h0);
        xfer(1'b0, SDT_ADDR_COUNT, 32'h0);
        inrange(r[7:0], 8'h35, 8'h35, "low on system clock");
        chk({24'h0, r[15:8]}, 32'h0, "high gated off");
        end_of_test();
    end
endmodule // sdt_split_timer_tb
